// *** tb_windowed_watchdog_supervisor.sv ***
// Self-checking bench for the windowed watchdog supervisor.
// Assumes the design files and the processor model are compiled first.
`timescale 1ns/10ps
module tb_windowed_watchdog_supervisor;
    localparam int EARLY = 20;
    localparam int LATE = 50;
    localparam int STRETCH = 30;
    localparam int PULSE = 8;
    logic clk, rst, supply_good, operator_reset_n, kick_in, run;
    logic [7:0] gap;
    logic reset_n, od, oe, fault_fast, fault_slow;
    int mismatches = 0;
    int check_count = 0;
    int n;

    wws_supervisor #(.EARLY_CYC(EARLY), .LATE_CYC(LATE), .STRETCH_CYC(STRETCH),
        .PULSE_CYC(PULSE)) u_dut (.clk(clk), .rst(rst), .supply_good(supply_good),
        .operator_reset_n(operator_reset_n), .kick_in(kick_in), .reset_n(reset_n),
        .window_fault_pulse_n_o(od), .window_fault_pulse_n_oe(oe),
        .fault_fast(fault_fast), .fault_slow(fault_slow));
    wws_cpu_model u_cpu (.clk(clk), .run(run), .gap(gap), .kick_in(kick_in));

    // Free-running system clock, 100 ns period.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Outputs are read 1 ns after the edge so that its updates have landed.
    task tick;
        @(posedge clk);
        #1;
    endtask

    task chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task chk_cnt(input int got, input int lo, input int hi);
        check_count++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("unexpected t=%0t got=%0h exp=%0h..%0h", $time, got, lo, hi);
        end
    endtask

    // Bounded waits; an overrun shows up as an out-of-range count.
    task wait_rn(input logic v, output int c);
        c = 0;
        while (reset_n !== v && c < 3000) begin
            tick;
            c++;
        end
    endtask

    task wait_oe(input logic v, output int c);
        c = 0;
        while (oe !== v && c < 3000) begin
            tick;
            c++;
        end
    endtask

    task count_oe(input int span, output int c);
        c = 0;
        repeat (span) begin
            tick;
            if (oe !== 1'b0) c++;
        end
    endtask

    // Power-up stretch, then slow faults with no kicks at all.
    task t_power_slow;
        @(posedge clk);
        rst <= 1'b0;
        wait_rn(1'b1, n);
        chk_cnt(n, STRETCH, STRETCH + 4);
        wait_oe(1'b1, n);
        chk_cnt(n, LATE - 1, LATE + 2);
        chk_bit(fault_slow, 1'b1);
        chk_bit(fault_fast, 1'b0);
        chk_bit(od, 1'b0);
        wait_oe(1'b0, n);
        chk_cnt(n, PULSE, PULSE);
        chk_bit(reset_n, 1'b1);
        wait_oe(1'b1, n);
        chk_cnt(n, LATE - 1, LATE + 2);
    endtask

    // Kicks inside the window after a pulse raise nothing.
    task t_window;
        wait_oe(1'b0, n);
        gap <= 8'h23;
        run <= 1'b1;
        count_oe(300, n);
        chk_cnt(n, 0, 0);
    endtask

    // Early kick gives a fast fault; kicks during the pulse are ignored.
    task t_fast;
        gap <= 8'h0a;
        wait_oe(1'b1, n);
        chk_cnt(n, 1, 60);
        chk_bit(fault_fast, 1'b1);
        chk_bit(fault_slow, 1'b0);
        gap <= 8'h05;
        wait_oe(1'b0, n);
        chk_cnt(n, PULSE, PULSE);
        run <= 1'b0;
        count_oe(20, n);
        chk_cnt(n, 0, 0);
    endtask

    // A short operator glitch is filtered; a held low resets and stretches.
    task t_operator;
        @(posedge clk);
        operator_reset_n <= 1'b0;
        repeat (5) @(posedge clk);
        operator_reset_n <= 1'b1;
        wait_rn(1'b0, n);
        chk_cnt(n, 3000, 3000);
        @(posedge clk);
        operator_reset_n <= 1'b0;
        repeat (20) @(posedge clk);
        #1;
        chk_bit(reset_n, 1'b0);
        chk_bit(oe, 1'b0);
        @(posedge clk);
        operator_reset_n <= 1'b1;
        wait_rn(1'b1, n);
        chk_cnt(n, STRETCH, STRETCH + 6);
    endtask

    // Supply dropping below trip asserts reset until it has been good long enough.
    task t_supply;
        @(posedge clk);
        supply_good <= 1'b0;
        wait_rn(1'b0, n);
        chk_cnt(n, 0, 3);
        repeat (10) @(posedge clk);
        #1;
        chk_bit(oe, 1'b0);
        @(posedge clk);
        supply_good <= 1'b1;
        wait_rn(1'b1, n);
        chk_cnt(n, STRETCH, STRETCH + 3);
    endtask

    task close_out;
        $display("counts: mismatches=%0d checks=%0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Main sequence; reset is held for 16 cycles with supply good and no kicks.
    initial begin
        rst = 1'b1;
        supply_good = 1'b1;
        operator_reset_n = 1'b1;
        run = 1'b0;
        gap = 8'h23;
        repeat (15) @(posedge clk);
        t_power_slow;
        t_window;
        t_fast;
        t_operator;
        t_supply;
        close_out;
    end

    // The sequence needs about 4000 cycles; five times that means a hang.
    initial begin
        #(100 * 20000);
        mismatches++;
        close_out;
    end
endmodule // tb_windowed_watchdog_supervisor

// *** wws_cfg.svh ***
// Timing and filter constants for the windowed watchdog supervisor.
// Assumes a 10 MHz system clock; all counts derive from the printed times.
`ifndef WWS_CFG_SVH
`define WWS_CFG_SVH

`define WWS_CLK_NS 100
`define WWS_STRETCH_MS 100
`define WWS_STRETCH_CYC ((`WWS_STRETCH_MS * 1000000 + `WWS_CLK_NS - 1) / `WWS_CLK_NS)
`define WWS_PULSE_MS 1
`define WWS_PULSE_CYC ((`WWS_PULSE_MS * 1000000) / `WWS_CLK_NS)
`define WWS_EARLY_MS 10
`define WWS_EARLY_CYC ((`WWS_EARLY_MS * 1000000 + `WWS_CLK_NS - 1) / `WWS_CLK_NS)
`define WWS_LATE_MS 15
`define WWS_LATE_CYC ((`WWS_LATE_MS * 1000000) / `WWS_CLK_NS)
`define WWS_GLITCH_NS 1000
`define WWS_GLITCH_CYC ((`WWS_GLITCH_NS + `WWS_CLK_NS - 1) / `WWS_CLK_NS)
`define WWS_CNT_W 24

`endif

// *** wws_cpu_model.sv ***
// Behavioural model of the supervised processor that drives the kick pin.
// Assumes one clock; the bench sets the fall spacing and starts or stops it.
`timescale 1ns/10ps
module wws_cpu_model (
    input wire logic clk,
    input wire logic run,
    input wire logic [7:0] gap,
    output logic kick_in
);
    logic [7:0] cnt_reg;

    // One falling edge every gap cycles, low for two cycles; idle high when stopped.
    always_ff @(posedge clk) begin
        if (!run) begin
            cnt_reg <= 8'h00;
            kick_in <= 1'b1;
        end else begin
            cnt_reg <= (cnt_reg >= gap - 8'h01) ? 8'h00 : cnt_reg + 8'h01;
            kick_in <= (cnt_reg >= 8'h02);
        end
    end
endmodule // wws_cpu_model

// *** wws_debounce.sv ***
// Low-level filter: output goes high only after a sustained low input.
// Assumes a synchronised input on the system clock.
`timescale 1ns/10ps
`include "wws_cfg.svh"
module wws_debounce
    import wws_pkg::*;
#(
    parameter int unsigned HOLD_CYC = `WWS_GLITCH_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic din,
    output logic low_reg
);
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic hit;

    // Count consecutive low samples; any high sample restarts the count.
    assign hit = (cnt_reg >= 16'(HOLD_CYC - 1));
    assign cnt_next = din ? 16'h0000 : (hit ? cnt_reg : cnt_reg + 16'h0001);

    // Release is immediate so the stretch timer starts from the real rise.
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg <= 16'h0000;
            low_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            low_reg <= !din && hit;
        end
    end
endmodule // wws_debounce

// *** wws_pkg.sv ***
// Types shared by the windowed watchdog supervisor files.
// Assumes the constants header is included by each user.
package wws_pkg;
    typedef enum logic [1:0] {WWS_RESET, WWS_ARMED, WWS_RUN, WWS_PULSE} wws_state_t;
    typedef struct packed {
        logic kick_fall;
        logic operator_low;
    } wws_events_t;
endpackage

// *** wws_supervisor.sv ***
// Windowed watchdog supervisor: reset generator and kick window checker.
// Assumes one 10 MHz clock, a synchronous supply-good input from the
// analogue comparator, and asynchronous kick and operator reset pins.
// Functional notes
// - Operator reset low asserts reset, clears watchdog timer, releases fault output.
// - After operator reset rises, reset stays asserted at least 100 ms.
// - Reset asserted while supply below trip level or operator reset low.
// - Release reset only after supply good and operator high for 100 ms.
// - Watchdog timer clears on each accepted kick fall and reset release.
// - Kick fall inside the early/late window raises no fault, restarts timing.
// - Kick falls closer than early limit cause fast fault and low pulse.
// - No kick fall before late limit causes slow fault and low pulse.
// - Any fault drives the open-drain fault output low for 1 ms.
// - Fault output may only assert while reset is inactive.
// - Kick pulses are ignored while reset or fault output is asserted.
// - Watchdog timer clears when the fault pulse ends.
// - First kick fall after reset or fault pulse skips early check.
// - Operator reset filtered so short low glitches do not assert reset.
// - A watchdog fault never asserts the reset output itself.
`timescale 1ns/10ps
`include "wws_cfg.svh"
module wws_supervisor
    import wws_pkg::*;
#(
    parameter int unsigned EARLY_CYC = `WWS_EARLY_CYC,
    parameter int unsigned LATE_CYC = `WWS_LATE_CYC,
    parameter int unsigned STRETCH_CYC = `WWS_STRETCH_CYC,
    parameter int unsigned PULSE_CYC = `WWS_PULSE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic supply_good,
    input wire logic operator_reset_n,
    input wire logic kick_in,
    output logic reset_n,
    output logic window_fault_pulse_n_o,
    output logic window_fault_pulse_n_oe,
    output logic fault_fast,
    output logic fault_slow
);
    localparam int W = `WWS_CNT_W;

    logic kick_sync;
    logic op_sync;
    logic op_low;
    logic kick_d_reg;
    wws_events_t ev;
    logic hold;
    logic [W-1:0] rst_cnt_reg;
    logic [W-1:0] rst_cnt_next;
    logic rst_done;
    logic reset_n_reg;
    logic reset_n_next;
    wws_state_t state_reg;
    wws_state_t state_next;
    logic [W-1:0] wd_cnt_reg;
    logic [W-1:0] wd_cnt_next;
    logic first_reg;
    logic first_next;
    logic early_hit;
    logic late_hit;
    logic pulse_end;
    logic fast_evt;
    logic slow_evt;
    logic ff_fast_reg;
    logic ff_slow_reg;

    // Pin synchronisers ahead of any edge or level logic.
    wws_sync u_kick_sync (.clk(clk), .rst(rst), .din(kick_in), .dout(kick_sync));
    wws_sync u_op_sync (.clk(clk), .rst(rst), .din(operator_reset_n), .dout(op_sync));

    // Glitch filter; a low must last about a microsecond before it counts.
    wws_debounce #(.HOLD_CYC(`WWS_GLITCH_CYC)) u_op_filt (
        .clk(clk),
        .rst(rst),
        .din(op_sync),
        .low_reg(op_low)
    );

    // Kick falling edge detect on the synchronised level.
    always_ff @(posedge clk) begin
        if (rst) begin
            kick_d_reg <= 1'b1;
        end else begin
            kick_d_reg <= kick_sync;
        end
    end

    assign ev.kick_fall = kick_d_reg && !kick_sync;
    assign ev.operator_low = op_low;

    // Reset generator. Faults feed nothing here, so a watchdog fault alone
    // never resets the processor; loop the fault pin back for that.
    assign hold = !supply_good || ev.operator_low;
    assign rst_done = (rst_cnt_reg >= W'(STRETCH_CYC - 1));
    assign rst_cnt_next = hold ? '0 : (rst_done ? rst_cnt_reg : rst_cnt_reg + 1'b1);
    assign reset_n_next = !hold && rst_done;

    always_ff @(posedge clk) begin
        if (rst) begin
            rst_cnt_reg <= '0;
            reset_n_reg <= 1'b0;
        end else begin
            rst_cnt_reg <= rst_cnt_next;
            reset_n_reg <= reset_n_next;
        end
    end

    assign reset_n = reset_n_reg;

    // Window comparisons on the watchdog timer.
    assign early_hit = (wd_cnt_reg < W'(EARLY_CYC));
    assign late_hit = (wd_cnt_reg >= W'(LATE_CYC - 1));
    assign pulse_end = (wd_cnt_reg >= W'(PULSE_CYC - 1));
    assign fast_evt = (state_reg == WWS_RUN) && ev.kick_fall && early_hit && !first_reg;
    assign slow_evt = (state_reg == WWS_RUN) && !ev.kick_fall && late_hit;

    // Watchdog sequencer. The timer doubles as the pulse-width counter.
    always_comb begin
        state_next = state_reg;
        wd_cnt_next = wd_cnt_reg + 1'b1;
        first_next = first_reg;
        case (state_reg)
            WWS_RESET: begin
                wd_cnt_next = '0;
                first_next = 1'b1;
                if (reset_n_reg) begin
                    state_next = WWS_RUN;
                end
            end
            WWS_RUN: begin
                if (fast_evt || slow_evt) begin
                    state_next = WWS_PULSE;
                    wd_cnt_next = '0;
                end else if (ev.kick_fall) begin
                    wd_cnt_next = '0;
                    first_next = 1'b0;
                end
            end
            WWS_PULSE: begin
                // Kicks are not looked at in this state.
                if (pulse_end) begin
                    state_next = WWS_RUN;
                    wd_cnt_next = '0;
                    first_next = 1'b1;
                end
            end
            default: begin
                state_next = WWS_RESET;
                wd_cnt_next = '0;
            end
        endcase
        if (!reset_n_next) begin
            // Reset overrides everything and releases the fault pin in the
            // same cycle in which reset falls, so the pin never pulls while
            // reset is low.
            state_next = WWS_RESET;
            wd_cnt_next = '0;
            first_next = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= WWS_RESET;
            wd_cnt_reg <= '0;
            first_reg <= 1'b1;
            ff_fast_reg <= 1'b0;
            ff_slow_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            wd_cnt_reg <= wd_cnt_next;
            first_reg <= first_next;
            ff_fast_reg <= fast_evt && reset_n_next;
            ff_slow_reg <= slow_evt && reset_n_next;
        end
    end

    // Open drain: output data always low, enable pulls the line.
    assign window_fault_pulse_n_o = 1'b0;
    assign window_fault_pulse_n_oe = (state_reg == WWS_PULSE);
    assign fault_fast = ff_fast_reg;
    assign fault_slow = ff_slow_reg;

    // Checker-only counters. They run beside the sequencer rather than
    // reusing its timer, so a wrong compare in the timer still shows up.
    // They cost a few registers that synthesis drops as unread.
    logic [W-1:0] good_cnt_reg;
    logic [W-1:0] oe_cnt_reg;
    logic [W-1:0] idle_cnt_reg;

    // Cycles for which both reset causes have been clear, saturating.
    always_ff @(posedge clk) begin
        if (rst || hold) begin
            good_cnt_reg <= '0;
        end else if (good_cnt_reg < W'(STRETCH_CYC)) begin
            good_cnt_reg <= good_cnt_reg + 1'b1;
        end
    end

    // Cycles for which the fault pin has been pulled in the current pulse.
    always_ff @(posedge clk) begin
        if (rst || !window_fault_pulse_n_oe) begin
            oe_cnt_reg <= '0;
        end else begin
            oe_cnt_reg <= oe_cnt_reg + 1'b1;
        end
    end

    // Cycles spent in the run state since it was entered or last kicked.
    always_ff @(posedge clk) begin
        if (rst || state_reg != WWS_RUN || ev.kick_fall) begin
            idle_cnt_reg <= '0;
        end else begin
            idle_cnt_reg <= idle_cnt_reg + 1'b1;
        end
    end

    // Checks kept beside the logic they guard.
    sequence fault_start_s;
        $rose(window_fault_pulse_n_oe);
    endsequence

    operator_hold_a: assert property (@(posedge clk) disable iff (rst)
        ev.operator_low |=> !reset_n && !window_fault_pulse_n_oe)
        else $error("reset or fault pin active during operator reset");

    supply_hold_a: assert property (@(posedge clk) disable iff (rst)
        !supply_good |=> !reset_n)
        else $error("reset released while supply is low");

    stretch_min_a: assert property (@(posedge clk) disable iff (rst)
        $rose(reset_n) |-> rst_cnt_reg >= W'(STRETCH_CYC - 1) && !$past(hold))
        else $error("reset released before stretch time");

    fault_width_a: assert property (@(posedge clk) disable iff (rst)
        fault_start_s ##1 reset_n[*1] |-> window_fault_pulse_n_oe
            || !$past(reset_n))
        else $error("fault pulse shorter than two cycles");

    fault_gate_a: assert property (@(posedge clk) disable iff (rst)
        window_fault_pulse_n_oe |-> reset_n)
        else $error("fault pin active while reset asserted");

    fast_fault_a: assert property (@(posedge clk) disable iff (rst)
        fast_evt && reset_n_next |=> window_fault_pulse_n_oe && fault_fast)
        else $error("early kick did not start a fault pulse");

    slow_fault_a: assert property (@(posedge clk) disable iff (rst)
        slow_evt && reset_n_next |=> window_fault_pulse_n_oe && fault_slow)
        else $error("late timeout did not start a fault pulse");

    first_free_a: assert property (@(posedge clk) disable iff (rst)
        first_reg && ev.kick_fall && state_reg == WWS_RUN |=> !window_fault_pulse_n_oe)
        else $error("first kick raised a fast fault");

    restart_a: assert property (@(posedge clk) disable iff (rst)
        $fell(window_fault_pulse_n_oe) && reset_n |-> wd_cnt_reg == '0)
        else $error("timer not cleared at fault pulse end");

    no_reset_fault_a: assert property (@(posedge clk) disable iff (rst)
        supply_good && !ev.operator_low && reset_n |=> reset_n)
        else $error("fault caused a reset");

    // Checks against the independent counters above; release_clear_a checks the sequencer timer.
    sequence reset_release_s;
        $rose(reset_n);
    endsequence

    stretch_count_a: assert property (@(posedge clk) disable iff (rst)
        reset_release_s |-> good_cnt_reg >= W'(STRETCH_CYC))
        else $error("reset released before the causes cleared long enough");

    release_clear_a: assert property (@(posedge clk) disable iff (rst)
        reset_release_s |=> wd_cnt_reg == '0)
        else $error("timer not cleared at reset release");

    pulse_len_a: assert property (@(posedge clk) disable iff (rst)
        $fell(window_fault_pulse_n_oe) && reset_n |-> oe_cnt_reg == W'(PULSE_CYC))
        else $error("fault pulse length differs from the set width");

    idle_bound_a: assert property (@(posedge clk) disable iff (rst)
        idle_cnt_reg <= W'(LATE_CYC))
        else $error("no slow fault after the late limit");

    slow_time_a: assert property (@(posedge clk) disable iff (rst)
        fault_slow |-> idle_cnt_reg == W'(LATE_CYC))
        else $error("slow fault raised at the wrong time");

    fast_time_a: assert property (@(posedge clk) disable iff (rst)
        fault_fast |-> $past(idle_cnt_reg) < W'(EARLY_CYC))
        else $error("fast fault raised for a kick inside the window");

    window_ok_a: assert property (@(posedge clk) disable iff (rst)
        state_reg == WWS_RUN && ev.kick_fall && idle_cnt_reg >= W'(EARLY_CYC)
            && !hold |=> !window_fault_pulse_n_oe)
        else $error("kick inside the window raised a fault");

    pulse_deaf_a: assert property (@(posedge clk) disable iff (rst)
        window_fault_pulse_n_oe && ev.kick_fall && !hold
            && oe_cnt_reg < W'(PULSE_CYC - 1) |=> window_fault_pulse_n_oe)
        else $error("kick cut the fault pulse short");
endmodule // wws_supervisor

// *** wws_sync.sv ***
// Two-flop synchroniser for pin inputs.
// Assumes asynchronous inputs; the reset value is the idle (high) level.
`timescale 1ns/10ps
module wws_sync
    import wws_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    logic meta_reg;

    // The first stage feeds only the second stage to contain metastability.
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= 1'b1;
            dout <= 1'b1;
        end else begin
            meta_reg <= din;
            dout <= meta_reg;
        end
    end
endmodule // wws_sync
